//--- ccef_pkg.sv
// ccef_pkg: register map, field positions and reset values of the comparator control bank.
// assumes: used by the control bank top and its per-comparator channel module.
`default_nettype none

package ccef_pkg;

  // comparator count
  localparam int unsigned NUM_COMP = 2;

  // register byte addresses on the wishbone bus (two bytes apart, so 8'h9a is not word aligned)
  localparam logic [7:0] COMP_A_CTRL_ADDR = 8'h98;
  localparam logic [7:0] COMP_B_CTRL_ADDR = 8'h9a;
  localparam logic [7:0] COMP_B_CTRL_IDX = 8'h9a;

  // field positions inside comparator_control_reg
  localparam int unsigned NEG_HYST_LSB = 0;
  localparam int unsigned POS_HYST_LSB = 2;
  localparam int unsigned FALL_FLAG_BIT = 4;
  localparam int unsigned RISE_FLAG_BIT = 5;
  localparam int unsigned OUT_STATE_BIT = 6;
  localparam int unsigned ENABLE_BIT = 7;

  // reset value of every control register
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] HYST_RESET = 2'h0;

  // hysteresis codes: 00 off, 01 5 mV, 10 10 mV, 11 20 mV
  typedef enum logic [1:0] {
    HYST_OFF = 2'h0,
    HYST_5MV = 2'h1,
    HYST_10MV = 2'h2,
    HYST_20MV = 2'h3
  } ccef_hyst_type;

  // depth of the input synchroniser
  localparam int unsigned SYNC_STAGES = 2;

endpackage : ccef_pkg

`default_nettype wire

//--- ccef_chan_if.sv
// ccef_chan_if: bundle between the register bank and one comparator channel.
// assumes: one instance per comparator, driven on a single clock.
`timescale 1ns/1ps
`default_nettype none

interface ccef_chan_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic enable;
  logic [1:0] pos_hyst;
  logic [1:0] neg_hyst;

  // bank side writes and reads
  modport bank (output wr_en, output wr_data, input rd_data, input enable,
                input pos_hyst, input neg_hyst);
  // channel side holds the state
  modport chan (input wr_en, input wr_data, output rd_data, output enable,
                output pos_hyst, output neg_hyst);
endinterface : ccef_chan_if

`default_nettype wire

//--- ccef_chan.sv
// ccef_chan: one comparator's control register, synchroniser and sticky edge flags.
// assumes: cmp_out_i is asynchronous; writes arrive as single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module ccef_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw comparator output from the analog core
  input wire logic cmp_out_i,
  // register side
  ccef_chan_if.chan ch,
  // one-cycle edge events toward the interrupt logic
  output logic rise_evt_o,
  output logic fall_evt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [ccef_pkg::SYNC_STAGES-1:0] sync_r, sync_nxt;
  logic prev_r, prev_nxt;
  logic en_r, en_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;
  logic [1:0] pos_r, pos_nxt;
  logic [1:0] neg_r, neg_nxt;
  logic out_s;
  logic rise_det;
  logic fall_det;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    // two flops before anyone looks at the comparator output
    sync_nxt = {sync_r[ccef_pkg::SYNC_STAGES-2:0], cmp_out_i}; // RULE12
    out_s = sync_r[ccef_pkg::SYNC_STAGES-1];
    prev_nxt = out_s;
    // edges only count while enabled; prev tracks always so enabling adds no edge
    rise_det = en_r & out_s & ~prev_r; // RULE12
    fall_det = en_r & ~out_s & prev_r; // RULE12
    en_nxt = en_r;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    if (ch.wr_en) begin
      en_nxt = ch.wr_data[ccef_pkg::ENABLE_BIT]; // RULE10
      pos_nxt = ch.wr_data[ccef_pkg::POS_HYST_LSB +: 2]; // RULE4
      neg_nxt = ch.wr_data[ccef_pkg::NEG_HYST_LSB +: 2]; // RULE3
      rise_nxt = ch.wr_data[ccef_pkg::RISE_FLAG_BIT]; // RULE8
      fall_nxt = ch.wr_data[ccef_pkg::FALL_FLAG_BIT]; // RULE8
    end
    // a set in the same cycle as a software clear wins
    if (rise_det) begin
      rise_nxt = 1'b1; // RULE7
    end
    if (fall_det) begin
      fall_nxt = 1'b1; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= '0;
      prev_r <= 1'b0;
      en_r <= ccef_pkg::CTRL_RESET[ccef_pkg::ENABLE_BIT]; // RULE10
      pos_r <= ccef_pkg::HYST_RESET;
      neg_r <= ccef_pkg::HYST_RESET;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      en_r <= en_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ch.enable = en_r;
  assign ch.pos_hyst = pos_r; // RULE2
  assign ch.neg_hyst = neg_r; // RULE2
  // bit 6 always shows the live synchronised output
  assign ch.rd_data = {en_r, out_s, rise_r, fall_r, pos_r, neg_r}; // RULE9
  assign rise_evt_o = rise_det; // RULE5
  assign fall_evt_o = fall_det; // RULE5

endmodule : ccef_chan

`default_nettype wire

//--- ccef_top.sv
// ccef_top: wishbone register bank for two voltage comparators with sticky edge flags.
// assumes: classic wishbone master on clk_i; comparator outputs are asynchronous pins.
//
// Overview of operation
// [RULE1] two comparators, zero and one, each with its own identical control register
// [RULE2] the four low bits hold hysteresis and drive the analog selection inputs
// [RULE3] bits 1-0 pick negative hysteresis: off, 5 mV, 10 mV or 20 mV
// [RULE4] bits 3-2 pick positive hysteresis with the same four codes
// [RULE5] each rising and each falling output transition can raise an interrupt request
// [RULE6] a falling output transition sets the fall flag in bit 4
// [RULE7] a rising output transition sets the rise flag in bit 5
// [RULE8] edge flags stay set until software writes them clear; hardware never clears
// [RULE9] bit 6 is read-only and shows the present comparator output state
// [RULE10] bit 7 enables the comparator; register resets to all zeros
// [RULE11] software clears both flags shortly after enabling or changing settings
// [RULE12] output is synchronised by two flops; edges detected only while enabled
`timescale 1ns/1ps
`default_nettype none

module ccef_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // analog comparator cores
  input wire logic [ccef_pkg::NUM_COMP-1:0] cmp_out_i,
  output logic [ccef_pkg::NUM_COMP-1:0] cmp_enable_o,
  output logic [2*ccef_pkg::NUM_COMP-1:0] pos_hyst_select_o,
  output logic [2*ccef_pkg::NUM_COMP-1:0] neg_hyst_select_o,
  // edge interrupt requests, one-cycle pulses per comparator
  output logic [ccef_pkg::NUM_COMP-1:0] rise_irq_o,
  output logic [ccef_pkg::NUM_COMP-1:0] fall_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic req;
  logic [ccef_pkg::NUM_COMP-1:0] hit;
  logic any_hit;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] rd_mux;
  logic [ccef_pkg::NUM_COMP-1:0][7:0] rd_bus;

  // a new request only when no answer is standing, so each access acks once
  assign req = cyc_i & stb_i & ~ack_r & ~err_r;
  assign hit[0] = (adr_i == ccef_pkg::COMP_A_CTRL_ADDR); // RULE1
  assign hit[1] = (adr_i == ccef_pkg::COMP_B_CTRL_ADDR); // RULE1
  assign any_hit = |hit;

  ////////////////////////////////////////////////////////////////////////////
  // per-comparator channels
  genvar g;
  generate
    for (g = 0; g < ccef_pkg::NUM_COMP; g++) begin : g_chan
      ccef_chan_if cif ();
      // writes need lane 0, which holds the whole 8-bit register
      assign cif.wr_en = req & we_i & hit[g] & sel_i[0];
      assign cif.wr_data = dat_i[7:0];
      assign rd_bus[g] = cif.rd_data;
      assign cmp_enable_o[g] = cif.enable; // RULE10
      assign pos_hyst_select_o[2*g +: 2] = cif.pos_hyst; // RULE4
      assign neg_hyst_select_o[2*g +: 2] = cif.neg_hyst; // RULE3
      ccef_chan u_chan (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cmp_out_i (cmp_out_i[g]),
        .ch (cif.chan),
        .rise_evt_o (rise_irq_o[g]),
        .fall_evt_o (fall_irq_o[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // answer logic: ack one cycle after the request, err on unmapped addresses
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < ccef_pkg::NUM_COMP; i++) begin
      if (hit[i]) begin
        rd_mux = rd_bus[i]; // RULE9
      end
    end
    ack_nxt = req & any_hit;
    err_nxt = req & ~any_hit;
    dat_nxt = dat_r;
    if (req & any_hit & ~we_i) begin
      dat_nxt = {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign err_o = err_r;
  assign dat_o = dat_r;

endmodule : ccef_top

`default_nettype wire

//--- ccef_cmp_model.sv
// ccef_cmp_model: behavioural analog core pair feeding the bank.
// assumes: bench sets which input is higher; one clock.
`timescale 1ns/1ps
`default_nettype none
module ccef_cmp_model (
  // clock and enables from the bank
  input wire logic clk_i,
  input wire logic [1:0] enable_i,
  // bench: positive input above negative
  input wire logic [1:0] above_i,
  // outputs toward the bank
  output logic [1:0] out_o
);
  // a powered-down core reads low, so enabling it can show a false rise
  always_ff @(posedge clk_i) begin
    out_o <= enable_i & above_i;
  end
endmodule : ccef_cmp_model
`default_nettype wire

//--- ccef_asserts.sv
// ccef_asserts: port checks of the comparator bank.
// assumes: bound into ccef_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ccef_asserts (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic err_o,
  // comparator side
  input wire logic [1:0] cmp_out_i,
  input wire logic [1:0] cmp_enable_o,
  input wire logic [3:0] pos_hyst_select_o,
  input wire logic [3:0] neg_hyst_select_o,
  input wire logic [1:0] rise_irq_o,
  input wire logic [1:0] fall_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request counts once; the answered cycle is not retaken
  logic req;
  logic hit;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit = adr_i == 8'h98 || adr_i == 8'h9a;
  sequence s_wr0;
    req && we_i && sel_i[0] && adr_i == 8'h98;
  endsequence
  sequence s_rise0;
    $rose(cmp_out_i[0]) && cmp_enable_o[0];
  endsequence
  a_map_ack: assert property (req && hit |=> ack_o && !err_o)
    else $error("mapped access not acked");
  a_unmap_err: assert property (req && !hit |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_answer_once: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
    else $error("answer longer than one cycle");
  a_hyst_drive: assert property (s_wr0 |=> pos_hyst_select_o[1:0] == $past(dat_i[3:2])
    && neg_hyst_select_o[1:0] == $past(dat_i[1:0])) else $error("hysteresis not driven");
  a_enable_drive: assert property (s_wr0 |=> cmp_enable_o[0] == $past(dat_i[7]))
    else $error("enable not driven");
  a_rise_event: assert property (s_rise0 |-> ##[1:8] rise_irq_o[0])
    else $error("rise not reported");
  a_fall_event: assert property ($fell(cmp_out_i[0]) && cmp_enable_o[0] |-> ##[1:8] fall_irq_o[0])
    else $error("fall not reported");
  a_event_gated: assert property ((rise_irq_o[0] || fall_irq_o[0]) |-> cmp_enable_o[0])
    else $error("edge while disabled");
endmodule : ccef_asserts
bind ccef_top ccef_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .err_o(err_o),
  .cmp_out_i(cmp_out_i), .cmp_enable_o(cmp_enable_o), .pos_hyst_select_o(pos_hyst_select_o),
  .neg_hyst_select_o(neg_hyst_select_o), .rise_irq_o(rise_irq_o), .fall_irq_o(fall_irq_o));
`default_nettype wire

//--- ccef_tb.sv
// testbench: wishbone master and register model for the comparator bank.
// assumes: ccef_top, ccef_cmp_model and ccef_asserts compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err;
  logic [7:0] adr = 8'h0, d;
  logic [3:0] sel = 4'h0, ph, nh;
  logic [31:0] wd = 32'h0, rd, q, lfsr = 32'h74de0e82;
  logic [1:0] above = 2'h0, cout, en, rirq, firq;
  logic e;
  logic [7:0] mreg [2] = '{8'h0, 8'h0};
  int n_errors = 0, compares = 0, cyc_cnt = 0, n_rise = 0, n_fall = 0;
  ccef_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .err_o(err), .cmp_out_i(cout),
    .cmp_enable_o(en), .pos_hyst_select_o(ph), .neg_hyst_select_o(nh), .rise_irq_o(rirq),
    .fall_irq_o(firq));
  ccef_cmp_model core (.clk_i(clk_i), .enable_i(en), .above_i(above), .out_o(cout));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // cycle ceiling and event counter
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    // one-cycle edge pulses of both channels
    n_rise <= n_rise + int'(rirq[0] === 1'b1) + int'(rirq[1] === 1'b1);
    n_fall <= n_fall + int'(firq[0] === 1'b1) + int'(firq[1] === 1'b1);
    if (cyc_cnt == 6000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // next state of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // classic cycle: hold until ack or err is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dv, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, dv};
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rd;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // the core reads low while off, so enabling with its input high shows a rise
  task automatic wr(input int g, input logic [7:0] dv);
    bus(1'b1, g ? 8'h9a : 8'h98, dv, 4'h1);
    if (!mreg[g][7] && dv[7] && above[g]) dv[5] = 1'b1;
    mreg[g] = dv & 8'hbf;
    repeat (8) @(posedge clk_i);
  endtask : wr
  task automatic rchk(input int g);
    bus(1'b0, g ? 8'h9a : 8'h98, 8'h0, 4'h1);
    check(q, {24'h0, mreg[g] | {1'b0, mreg[g][7] & above[g], 6'h0}});
  endtask : rchk
  // flags only move while enabled; wait out the synchroniser
  task automatic pin(input int g, input logic v);
    @(posedge clk_i);
    if (mreg[g][7] && v != above[g]) mreg[g][v ? 5 : 4] = 1'b1;
    above[g] <= v;
    repeat (8) @(posedge clk_i);
  endtask : pin
  task automatic test_done();
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int g = 0; g < 2; g++) rchk(g);
    bus(1'b0, 8'h9c, 8'h0, 4'h1);
    check(e, 1'b1);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr[7:4] & 4'h7, i[3:0]};
      wr(i % 2, d);
      check({en[i%2], ph[2*(i%2)+:2], nh[2*(i%2)+:2]}, {d[7], d[3:0]});
      rchk(i % 2);
    end
    bus(1'b1, 8'h98, 8'hff, 4'he);
    rchk(0);
    for (int g = 0; g < 2; g++) begin
      wr(g, 8'h80);
      pin(g, 1'b1);
      rchk(g);
      pin(g, 1'b0);
      rchk(g);
      wr(g, 8'h00);
      pin(g, 1'b1);
      rchk(g);
      wr(g, 8'h80);
      rchk(g);
      wr(g, 8'h80);
      pin(g, 1'b0);
      rchk(g);
      pin(g, 1'b1);
      rchk(g);
      // disabling with the input high drops the core output; gating must hide that fall
      wr(g, 8'h00);
      rchk(g);
      pin(g, 1'b0);
    end
    // a mid-run reset from a non-zero state must clear both registers again
    wr(0, 8'h9f);
    wr(1, 8'h3f);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    mreg = '{8'h0, 8'h0};
    for (int g = 0; g < 2; g++) rchk(g);
    check(n_rise, 32'h6);
    check(n_fall, 32'h4);
    test_done();
  end
endmodule : testbench
`default_nettype wire
